// *** hdl/cpu_regs_and_indexed_addr_decode.sv ***
// Purpose: Core register set plus opcode, postbyte and extension byte decoder forming operand addresses.
// Assumes: Byte stream and memory byte reads are synchronous to clk_i; ce_i low freezes everything.
// Notes:   Execution unit writes registers through the load port; software sees only decoder status.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
module cpu_regs_and_indexed_addr_decode
  import cpu_regs_pkg::*;
#(
  parameter logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state when low
  input wire logic [7:0] fetch_byte_i, // Instruction stream byte
  input wire logic fetch_valid_i, // Instruction byte present
  input wire addr_mode_t mode_i, // Addressing mode of the opcode byte offered
  output logic fetch_ready_o, // Decoder takes a byte this cycle
  output logic mem_rd_o, // Byte read request to memory
  output logic [15:0] mem_addr_o, // Byte read address
  input wire logic [7:0] mem_byte_i, // Read data byte
  input wire logic mem_ack_i, // Read data valid
  input wire logic reg_wr_i, // Execution unit register load
  input wire reg_sel_t reg_sel_i, // Which register to load
  input wire logic [15:0] reg_wdata_i, // Load value, low byte for 8-bit targets
  input wire logic ccr_wr_i, // Execution unit flags load
  input wire logic [7:0] ccr_wdata_i, // New flags value
  output logic [7:0] opcode_o, // Last opcode byte
  output logic page2_o, // Last opcode came from second page
  output logic [7:0] postbyte_o, // Last postbyte
  output idx_kind_t idx_kind_o, // Indexed form of last instruction
  output logic [15:0] ea_o, // Effective operand address
  output logic ea_valid_o, // One-cycle pulse, instruction decoded
  output logic illegal_o, // One-cycle pulse with ea_valid_o, invalid postbyte
  output logic [7:0] acc_a_o, // First accumulator
  output logic [7:0] acc_b_o, // Second accumulator
  output logic [15:0] acc_d_o, // Double accumulator
  output logic [15:0] idx_x_o, // First index register
  output logic [15:0] idx_y_o, // Second index register
  output logic [15:0] sp_o, // Stack pointer
  output logic [15:0] pc_o, // Program counter
  output logic [7:0] ccr_o, // Full flags register
  output logic [3:0] branch_flags_o, // N Z V C for branch tests
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);

  // ****************************************
  // State record
  // ****************************************
  typedef enum logic [4:0] {
    st_rd_hi = 5'b00001,
    st_rd_lo = 5'b00010,
    st_opcode = 5'b00100,
    st_postbyte = 5'b01000,
    st_ext = 5'b10000
  } state_t;

  typedef struct packed {
    state_t state;
    logic vec_fetch;
    logic [7:0] acc_a;
    logic [7:0] acc_b;
    logic [15:0] idx_x;
    logic [15:0] idx_y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] condition_flags_register;
    logic page2_pend;
    logic page2;
    logic [7:0] opcode;
    addr_mode_t mode;
    logic [7:0] postbyte;
    idx_kind_t kind;
    logic [1:0] ext_left;
    logic [15:0] ext_word;
    logic [15:0] imm_addr;
    logic [15:0] ptr_addr;
    logic [7:0] ptr_hi;
    logic [15:0] ea;
    logic ea_valid;
    logic illegal;
    logic mem_rd;
    logic [15:0] mem_addr;
    logic fetch_ready;
    logic decode_en;
    logic ill_sticky;
    logic wb_ack;
    logic [31:0] wb_dat;
  } state_rec_t;

  localparam state_rec_t RESET_REC = '{
    state: st_rd_hi, vec_fetch: 1'b1, ptr_addr: RESET_VECTOR_ADDR,
    condition_flags_register: FLAGS_RESET, mode: inherent_mode, kind: no_index_kind,
    decode_en: 1'b1, default: '0};

  state_rec_t st;
  state_rec_t next_st;

  // ****************************************
  // Helpers
  // ****************************************
  // Base field sits high in short forms, in bits 4:3 in long forms
  function automatic logic [1:0] rr_of(input logic [7:0] pb);
    rr_of = (pb[7:5] == PB_LONG_FORM) ? pb[4:3] : pb[7:6];
  endfunction

  // Base register pick; pc seen here is already past the consumed byte
  function automatic logic [15:0] base_of(input logic [1:0] rr, input state_rec_t s, input logic [15:0] pcv);
    case (rr)
      RR_X: base_of = s.idx_x;
      RR_Y: base_of = s.idx_y;
      RR_STACK: base_of = s.sp;
      default: base_of = pcv;
    endcase
  endfunction

  // Auto-modify amount: 0..7 means +1..+8, 8..15 means -8..-1
  function automatic logic [15:0] step_of(input logic [3:0] n);
    step_of = n[3] ? {{12{1'b1}}, n} : {12'h000, n} + 16'h0001;
  endfunction

  logic take;
  logic [15:0] pc_inc;
  logic [15:0] ext_cat;
  logic [15:0] base_pb;
  logic [15:0] base_st;
  logic [15:0] acc_d;
  logic [15:0] mod_val;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.ea_valid = 1'b0;
    next_st.illegal = 1'b0;
    next_st.wb_ack = 1'b0;
    take = st.fetch_ready & fetch_valid_i;
    pc_inc = st.pc + 16'h0001;
    ext_cat = {st.ext_word[7:0], fetch_byte_i};
    acc_d = {st.acc_a, st.acc_b};
    base_pb = base_of(rr_of(fetch_byte_i), st, pc_inc);
    base_st = base_of(rr_of(st.postbyte), st, pc_inc);
    mod_val = base_pb + step_of(fetch_byte_i[3:0]);

    // Bus slave; clear applied first so a hardware set in this cycle wins
    if (wb_cyc_i && wb_stb_i && !st.wb_ack) begin
      next_st.wb_ack = 1'b1;
      next_st.wb_dat = 32'h0000_0000;
      if (wb_adr_i == ADDR_CTRL) begin
        next_st.wb_dat[CTRL_EN_BIT] = st.decode_en;
        if (wb_we_i && wb_sel_i[0]) begin
          next_st.decode_en = wb_dat_i[CTRL_EN_BIT];
        end
      end else if (wb_adr_i == ADDR_STATUS) begin
        next_st.wb_dat[STAT_ILL_BIT] = st.ill_sticky;
        next_st.wb_dat[STAT_PG2_BIT] = st.page2_pend;
        next_st.wb_dat[STAT_STATE_LSB +: 5] = st.state;
        if (wb_we_i && wb_sel_i[0] && wb_dat_i[STAT_ILL_BIT]) begin
          next_st.ill_sticky = 1'b0;
        end
      end else if (wb_adr_i == ADDR_EA) begin
        next_st.wb_dat[15:0] = st.ea;
      end else if (wb_adr_i == ADDR_INFO) begin
        next_st.wb_dat[15:0] = {st.opcode, st.postbyte};
        next_st.wb_dat[INFO_KIND_LSB +: 3] = st.kind;
        next_st.wb_dat[INFO_PAGE_BIT] = st.page2;
      end
    end

    // Decoder sequence
    case (st.state)
      st_rd_hi: begin
        if (!st.mem_rd) begin
          next_st.mem_rd = 1'b1;
          next_st.mem_addr = st.ptr_addr;
        end else if (mem_ack_i) begin
          next_st.mem_rd = 1'b0;
          next_st.ptr_hi = mem_byte_i;
          next_st.state = st_rd_lo;
        end
      end
      st_rd_lo: begin
        if (!st.mem_rd) begin
          next_st.mem_rd = 1'b1;
          next_st.mem_addr = st.ptr_addr + 16'h0001;
        end else if (mem_ack_i) begin
          next_st.mem_rd = 1'b0;
          next_st.state = st_opcode;
          if (st.vec_fetch) begin
            next_st.vec_fetch = 1'b0;
            next_st.pc = {st.ptr_hi, mem_byte_i};
          end else begin
            next_st.ea = {st.ptr_hi, mem_byte_i};
            next_st.ea_valid = 1'b1;
          end
        end
      end
      st_opcode: begin
        if (take) begin
          next_st.pc = pc_inc;
          if (fetch_byte_i == PAGE2_PREFIX && !st.page2_pend) begin
            next_st.page2_pend = 1'b1;
          end else begin
            next_st.page2_pend = 1'b0;
            next_st.page2 = st.page2_pend;
            next_st.opcode = fetch_byte_i;
            next_st.mode = mode_i;
            next_st.kind = no_index_kind;
            next_st.postbyte = 8'h00;
            next_st.ext_word = 16'h0000;
            next_st.imm_addr = pc_inc;
            next_st.ea = 16'h0000;
            case (mode_i)
              immediate_mode, direct_mode, relative_short_mode: begin
                next_st.ext_left = 2'd1;
                next_st.state = st_ext;
              end
              immediate_wide_mode, full_address_mode, relative_long_mode: begin
                next_st.ext_left = 2'd2;
                next_st.state = st_ext;
              end
              indexed_mode, postbyte_mode: begin
                next_st.state = st_postbyte;
              end
              default: begin
                next_st.ea_valid = 1'b1;
              end
            endcase
          end
        end
      end
      st_postbyte: begin
        if (take) begin
          next_st.pc = pc_inc;
          next_st.postbyte = fetch_byte_i;
          next_st.state = st_opcode;
          if (st.mode == postbyte_mode) begin
            next_st.ea_valid = 1'b1;
          end else if (!fetch_byte_i[5]) begin
            next_st.kind = indexed_short_mode;
            next_st.ea = base_pb + {{11{fetch_byte_i[4]}}, fetch_byte_i[4:0]};
            next_st.ea_valid = 1'b1;
          end else if (fetch_byte_i[7:5] != PB_LONG_FORM) begin
            next_st.kind = indexed_auto_mode;
            next_st.ea_valid = 1'b1;
            if (fetch_byte_i[7:6] == RR_PC) begin
              next_st.illegal = 1'b1;
              next_st.ill_sticky = 1'b1;
            end else begin
              next_st.ea = fetch_byte_i[4] ? base_pb : mod_val;
              case (fetch_byte_i[7:6])
                RR_X: next_st.idx_x = mod_val;
                RR_Y: next_st.idx_y = mod_val;
                default: next_st.sp = mod_val;
              endcase
            end
          end else if (!fetch_byte_i[2]) begin
            next_st.state = st_ext;
            if (fetch_byte_i[1] && fetch_byte_i[0]) begin
              next_st.kind = indexed_indirect_const_mode;
              next_st.ext_left = 2'd2;
            end else if (fetch_byte_i[1]) begin
              next_st.kind = indexed_sixteen_bit_mode;
              next_st.ext_left = 2'd2;
            end else begin
              next_st.kind = indexed_nine_bit_mode;
              next_st.ext_left = 2'd1;
            end
          end else begin
            next_st.kind = indexed_acc_mode;
            next_st.ea_valid = 1'b1;
            case (fetch_byte_i[1:0])
              AA_A: next_st.ea = base_pb + {8'h00, st.acc_a};
              AA_B: next_st.ea = base_pb + {8'h00, st.acc_b};
              AA_D: next_st.ea = base_pb + acc_d;
              default: begin
                next_st.kind = indexed_indirect_acc_mode;
                next_st.ea_valid = 1'b0;
                next_st.ptr_addr = base_pb + acc_d;
                next_st.state = st_rd_hi;
              end
            endcase
          end
        end
      end
      st_ext: begin
        if (take) begin
          next_st.pc = pc_inc;
          next_st.ext_word = ext_cat;
          next_st.ext_left = st.ext_left - 2'd1;
          if (st.ext_left == 2'd1) begin
            next_st.state = st_opcode;
            next_st.ea_valid = 1'b1;
            case (st.mode)
              immediate_mode, immediate_wide_mode: next_st.ea = st.imm_addr;
              direct_mode: next_st.ea = {8'h00, fetch_byte_i};
              full_address_mode: next_st.ea = ext_cat;
              relative_short_mode: next_st.ea = pc_inc + {{8{fetch_byte_i[7]}}, fetch_byte_i};
              relative_long_mode: next_st.ea = pc_inc + ext_cat;
              default: begin
                if (st.kind == indexed_nine_bit_mode) begin
                  next_st.ea = base_st + {{8{st.postbyte[0]}}, fetch_byte_i};
                end else if (st.kind == indexed_sixteen_bit_mode) begin
                  next_st.ea = base_st + ext_cat;
                end else begin
                  next_st.ea_valid = 1'b0;
                  next_st.ptr_addr = base_st + ext_cat;
                  next_st.state = st_rd_hi;
                end
              end
            endcase
          end
        end
      end
      default: begin
        next_st.state = st_opcode;
      end
    endcase

    // Execution unit loads take priority over decoder updates
    if (reg_wr_i) begin
      case (reg_sel_i)
        sel_a: next_st.acc_a = reg_wdata_i[7:0];
        sel_b: next_st.acc_b = reg_wdata_i[7:0];
        sel_d: begin
          next_st.acc_a = reg_wdata_i[15:8];
          next_st.acc_b = reg_wdata_i[7:0];
        end
        sel_x: next_st.idx_x = reg_wdata_i;
        sel_y: next_st.idx_y = reg_wdata_i;
        sel_sp: next_st.sp = reg_wdata_i;
        default: next_st.pc = reg_wdata_i;
      endcase
    end
    if (ccr_wr_i) begin
      next_st.condition_flags_register = ccr_wdata_i;
    end

    // Ready only where a stream byte is wanted and software allows it
    next_st.fetch_ready = next_st.decode_en &&
      (next_st.state == st_opcode || next_st.state == st_postbyte || next_st.state == st_ext);
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset record sets both masks and stop-disable, then starts vector fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= RESET_REC;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Registers leave only as ports, never through the bus map
  assign fetch_ready_o = st.fetch_ready;
  assign mem_rd_o = st.mem_rd;
  assign mem_addr_o = st.mem_addr;
  assign opcode_o = st.opcode;
  assign page2_o = st.page2;
  assign postbyte_o = st.postbyte;
  assign idx_kind_o = st.kind;
  assign ea_o = st.ea;
  assign ea_valid_o = st.ea_valid;
  assign illegal_o = st.illegal;
  assign acc_a_o = st.acc_a;
  assign acc_b_o = st.acc_b;
  assign acc_d_o = {st.acc_a, st.acc_b};
  assign idx_x_o = st.idx_x;
  assign idx_y_o = st.idx_y;
  assign sp_o = st.sp;
  assign pc_o = st.pc;
  assign ccr_o = st.condition_flags_register;
  // Half-carry stays out of branch flags; only decimal adjust may read it
  assign branch_flags_o = {st.condition_flags_register[FLAG_N], st.condition_flags_register[FLAG_Z], st.condition_flags_register[FLAG_V], st.condition_flags_register[FLAG_C]};
  assign wb_dat_o = st.wb_dat;
  assign wb_ack_o = st.wb_ack;

endmodule

// *** hdl/cpu_regs_pkg.sv ***
// Purpose: Shared constants and types of the core register set and operand address decoder.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Register bus offsets and field positions are word aligned on a 32-bit bus.
package cpu_regs_pkg;

  // ****************************************
  // Opcode paging and postbyte fields
  // ****************************************
  localparam logic [7:0] PAGE2_PREFIX = 8'h18;
  localparam logic [2:0] PB_LONG_FORM = 3'b111;
  localparam logic [1:0] RR_X = 2'b00;
  localparam logic [1:0] RR_Y = 2'b01;
  localparam logic [1:0] RR_STACK = 2'b10;
  localparam logic [1:0] RR_PC = 2'b11;
  localparam logic [1:0] AA_A = 2'b00;
  localparam logic [1:0] AA_B = 2'b01;
  localparam logic [1:0] AA_D = 2'b10;

  // ****************************************
  // Condition flags layout: S X H I N Z V C
  // ****************************************
  localparam int FLAG_S = 7;
  localparam int FLAG_X = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'hD0;

  // ****************************************
  // Register bus map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EA = 8'h08;
  localparam logic [7:0] ADDR_INFO = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_ILL_BIT = 0;
  localparam int STAT_PG2_BIT = 1;
  localparam int STAT_STATE_LSB = 8;
  localparam int INFO_KIND_LSB = 16;
  localparam int INFO_PAGE_BIT = 20;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    inherent_mode = 4'h0,
    immediate_mode = 4'h1,
    immediate_wide_mode = 4'h2,
    direct_mode = 4'h3,
    full_address_mode = 4'h4,
    relative_short_mode = 4'h5,
    relative_long_mode = 4'h6,
    indexed_mode = 4'h7,
    postbyte_mode = 4'h8
  } addr_mode_t;

  typedef enum logic [2:0] {
    no_index_kind = 3'h0,
    indexed_short_mode = 3'h1,
    indexed_auto_mode = 3'h2,
    indexed_nine_bit_mode = 3'h3,
    indexed_sixteen_bit_mode = 3'h4,
    indexed_acc_mode = 3'h5,
    indexed_indirect_const_mode = 3'h6,
    indexed_indirect_acc_mode = 3'h7
  } idx_kind_t;

  typedef enum logic [2:0] {
    sel_a = 3'h0,
    sel_b = 3'h1,
    sel_d = 3'h2,
    sel_x = 3'h3,
    sel_y = 3'h4,
    sel_sp = 3'h5,
    sel_pc = 3'h6
  } reg_sel_t;

endpackage

// *** verification/cpu_regs_properties.sv ***
// Purpose: Port-level checks of the register set and decoder.
// Assumes: clk_i only clock, rst_i synchronous active high.
// Notes:   Attached by the bind at the foot of this file.
`timescale 1ns/100ps
module cpu_regs_checker
  import cpu_regs_pkg::*;
#(
  parameter logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Reset
  input wire logic ce_i, // Clock enable
  input wire logic fetch_ready_o, // Stream ready
  input wire logic mem_rd_o, // Read request
  input wire logic [15:0] mem_addr_o, // Read address
  input wire logic mem_ack_i, // Read answer
  input wire logic [7:0] acc_a_o, // First accumulator
  input wire logic [7:0] acc_b_o, // Second accumulator
  input wire logic [15:0] acc_d_o, // Double accumulator
  input wire logic [7:0] ccr_o, // Flags
  input wire logic [3:0] branch_flags_o, // Branch flags
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o // Bus answer
);
  // ****
  // Bus answer steps
  // ****
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_wb_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req |=> s_wb_ans) else $error("bus answer not a single pulse");
  a_acc_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_d_o == {acc_a_o, acc_b_o}) else $error("double accumulator mismatch");
  a_branch_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    branch_flags_o == ccr_o[3:0]) else $error("branch flags differ from flags");
  a_read_held: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o)) else $error("read dropped early");
  a_read_release: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_rd_o && mem_ack_i |=> !mem_rd_o) else $error("read held after answer");
  a_no_fetch_read: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_rd_o |-> !fetch_ready_o) else $error("stream taken during read");
  // Reset checks run without disable since they watch reset itself
  a_reset_flags: assert property (@(posedge clk_i)
    rst_i |=> ccr_o == 8'hD0 && !fetch_ready_o && !mem_rd_o && !wb_ack_o) else $error("bad reset state");
  a_vector_fetch: assert property (@(posedge clk_i)
    rst_i ##1 !rst_i |=> mem_rd_o && mem_addr_o == RESET_VECTOR_ADDR) else $error("no vector read");
endmodule
bind cpu_regs_and_indexed_addr_decode cpu_regs_checker #(.RESET_VECTOR_ADDR(RESET_VECTOR_ADDR)) checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fetch_ready_o(fetch_ready_o), .mem_rd_o(mem_rd_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .acc_d_o(acc_d_o),
  .ccr_o(ccr_o), .branch_flags_o(branch_flags_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// *** verification/mem_model.sv ***
// Purpose: Byte memory answering the decoder's read requests.
// Assumes: One request at a time, held until answered.
// Notes:   slow_i stretches each answer by four cycles.
`timescale 1ns/100ps
module mem_model (
  input wire logic clk_i, // Core clock
  input wire logic rd_i, // Read request
  input wire logic [15:0] addr_i, // Read address
  input wire logic slow_i, // Answer late
  output logic [7:0] byte_o, // Read data
  output logic ack_o // One-cycle answer
);
  logic [7:0] mem [0:65535];
  logic [2:0] wait_cnt;
  initial begin
    byte_o = 8'h00;
    ack_o = 1'b0;
    wait_cnt = 3'h0;
  end
  // Data toggles between answers so a stale byte never looks valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    byte_o <= ~byte_o;
    if (!rd_i || ack_o) begin
      wait_cnt <= 3'h0;
    end else if (!slow_i || wait_cnt == 3'h4) begin
      ack_o <= 1'b1;
      byte_o <= mem[addr_i];
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench of the register set and decoder.
// Assumes: 100 MHz clock, inputs changed by NBA at rising edges.
// Notes:   Expected addresses are worked out by hand per scenario.
`timescale 1ns/100ps
module tb;
  import cpu_regs_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, fetch_valid_i = 1'b0, reg_wr_i = 1'b0, ccr_wr_i = 1'b0, slow = 1'b0;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] fetch_byte_i = 8'h00, ccr_wdata_i = 8'h00, wb_adr_i = 8'h00, mem_byte_i, acc_a_o, ccr_o;
  logic [7:0] opcode_o, postbyte_o;
  idx_kind_t idx_kind_o;
  logic [15:0] reg_wdata_i = 16'h0000, mem_addr_o, ea_o, idx_x_o, idx_y_o, sp_o, pc_o, pc_e;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
  logic mem_rd_o, mem_ack_i, fetch_ready_o, page2_o, ea_valid_o, wb_ack_o;
  addr_mode_t mode_i = inherent_mode;
  reg_sel_t reg_sel_i = sel_a;
  int failures = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  cpu_regs_and_indexed_addr_decode cpu_regs_and_indexed_addr_decode_i (.clk_i, .rst_i, .ce_i(ce),
    .fetch_byte_i, .fetch_valid_i, .mode_i, .fetch_ready_o, .mem_rd_o, .mem_addr_o, .mem_byte_i, .mem_ack_i,
    .reg_wr_i, .reg_sel_i, .reg_wdata_i, .ccr_wr_i, .ccr_wdata_i, .opcode_o, .page2_o, .postbyte_o,
    .idx_kind_o, .ea_o, .ea_valid_o, .illegal_o(), .acc_a_o, .acc_b_o(), .acc_d_o(), .idx_x_o, .idx_y_o,
    .sp_o, .pc_o, .ccr_o, .branch_flags_o(), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  mem_model mem_model_i (.clk_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o), .slow_i(slow), .byte_o(mem_byte_i),
    .ack_o(mem_ack_i));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ld(input reg_sel_t s, input logic [15:0] v);
    reg_wr_i <= 1'b1;
    reg_sel_i <= s;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Sends n bytes high first, then waits for the decode pulse
  task automatic run(input int n, input logic [31:0] bs, input addr_mode_t m, input logic [15:0] exp);
    for (int i = n - 1; i >= 0; i--) begin
      fetch_byte_i <= bs[8*i +: 8];
      mode_i <= m;
      fetch_valid_i <= 1'b1;
      do @(posedge clk_i); while (fetch_ready_o !== 1'b1);
      pc_e = pc_e + 16'h1;
    end
    fetch_valid_i <= 1'b0;
    for (int k = 0; k < 60 && ea_valid_o !== 1'b1; k++) @(posedge clk_i);
    chk(ea_valid_o, 32'h1);
    chk(ea_o, exp);
    chk(pc_o, pc_e);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk(ccr_o, 8'hD0);
    for (int k = 0; k < 60 && fetch_ready_o !== 1'b1; k++) @(posedge clk_i);
    chk(pc_o, 16'h1234);
    pc_e = 16'h1234;
    ccr_wr_i <= 1'b1;
    ccr_wdata_i <= 8'h2F;
    @(posedge clk_i);
    ccr_wr_i <= 1'b0;
    @(posedge clk_i);
    chk(ccr_o, 8'h2F);
  endtask
  task automatic t_bus();
    wb(1'b0, 8'h00, 32'h0);
    chk(rdata, 32'h1);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk(rdata, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    chk(fetch_ready_o, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
  endtask
  task automatic t_plain();
    run(2, 32'hA69A, direct_mode, 16'h009A);
    run(3, 32'hB65678, full_address_mode, 16'h5678);
    wb(1'b0, 8'h08, 32'h0);
    chk(rdata, 32'h5678);
    run(2, 32'h20FE, relative_short_mode, pc_e);
    run(3, 32'h170100, relative_long_mode, pc_e + 16'h0103);
  endtask
  task automatic t_indexed();
    ld(sel_x, 16'h1000);
    ld(sel_sp, 16'h3000);
    ld(sel_a, 16'h0005);
    run(2, 32'hA610, indexed_mode, 16'h0FF0);
    run(3, 32'hA6E100, indexed_mode, 16'h0F00);
    run(4, 32'hA6F20100, indexed_mode, 16'h3100);
    run(2, 32'hA6E4, indexed_mode, 16'h1005);
    run(2, 32'hA6C3, indexed_mode, pc_e + 16'h5);
    ld(sel_d, 16'h0010);
    chk(acc_a_o, 8'h00);
    // Load while the clock enable is low must not land
    ce <= 1'b0;
    ld(sel_x, 16'h4444);
    ce <= 1'b1;
    chk(idx_x_o, 16'h1000);
    run(2, 32'hA6E5, indexed_mode, 16'h1010);
    run(2, 32'hA6E6, indexed_mode, 16'h1010);
  endtask
  task automatic t_indirect();
    slow <= 1'b1;
    run(2, 32'hA6E7, indexed_mode, 16'hABCD);
    run(4, 32'hA6E30030, indexed_mode, 16'h55AA);
    slow <= 1'b0;
  endtask
  task automatic t_auto();
    ld(sel_y, 16'h2000);
    run(2, 32'hA671, indexed_mode, 16'h2000);
    chk(idx_y_o, 16'h2002);
    run(2, 32'hA62F, indexed_mode, 16'h0FFF);
    chk(idx_x_o, 16'h0FFF);
    run(2, 32'hA6A7, indexed_mode, 16'h3008);
    chk(sp_o, 16'h3008);
    chk(idx_kind_o, indexed_auto_mode);
    chk({opcode_o, postbyte_o}, 16'hA6A7);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rdata, 32'h0002A6A7);
  endtask
  task automatic t_page();
    run(2, 32'h1830, inherent_mode, 16'h0);
    chk(page2_o, 32'h1);
    run(1, 32'h30, inherent_mode, 16'h0);
    chk(page2_o, 32'h0);
    run(2, 32'hB70C, postbyte_mode, 16'h0);
  endtask
  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Vector and pointers preloaded; big-endian pairs
  initial begin
    mem_model_i.mem[16'hFFFE] = 8'h12;
    mem_model_i.mem[16'hFFFF] = 8'h34;
    mem_model_i.mem[16'h1010] = 8'hAB;
    mem_model_i.mem[16'h1011] = 8'hCD;
    mem_model_i.mem[16'h1030] = 8'h55;
    mem_model_i.mem[16'h1031] = 8'hAA;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bus();
    t_plain();
    t_indexed();
    t_indirect();
    t_auto();
    t_page();
    test_done();
  end
  // Whole run is under two hundred cycles; this cuts a hang
  initial begin
    #50000;
    failures++;
    test_done();
  end
endmodule
